// ---- design/dcache_maintenance_ops.sv ----
`timescale 1ns/1ps
`default_nettype none

module dcache_maintenance_ops (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Maintenance requests from the pipeline
  input wire logic req_valid_i,
  input wire dcm_pkg::req_t req_i,
  output logic req_ready_o,
  output logic done_o,
  output logic exc_valid_o,
  output dcm_pkg::cause_t exc_cause_o,
  output logic [31:0] exception_virtual_address_reg_o,
  // Translation
  output logic xlate_req_o,
  output logic [31:0] xlate_vaddr_o,
  input wire logic xlate_valid_i,
  input wire dcm_pkg::xlate_rsp_t xlate_i,
  // Tag memory check
  input wire logic tag_err_i,
  // Line writeback to memory
  output logic wb_valid_o,
  output logic [31:0] wb_addr_o,
  input wire logic wb_ready_i,
  // Ordinary and locking line fills
  input wire logic fill_valid_i,
  input wire dcm_pkg::fill_t fill_i,
  output logic fill_ack_o
);

  localparam int unsigned W = dcm_pkg::WAYS;
  localparam int unsigned SB = dcm_pkg::SET_BITS;
  localparam int unsigned TB = dcm_pkg::TAG_BITS;

  // ==========================================================
  // Reset release
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n <= rst_meta_q;
    end
  end

  // ==========================================================
  // Request checks
  dcm_pkg::state_t state_q, state_d;
  dcm_pkg::op_t op_q;
  logic [31:0] vaddr_q;
  logic [31:0] line_q;
  logic [31:0] vaddr_w;
  logic req_take, priv_op, illegal_w, priv_w, early_exc;
  logic st_idle, st_xlate, st_act, st_wb;

  dcm_addr_former dcm_addr_former_inst (
    .op_i(req_i.op),
    .base_i(req_i.base),
    .offset_i(req_i.offset),
    .vaddr_o(vaddr_w)
  );

  assign st_idle = (state_q == dcm_pkg::ST_IDLE);
  assign st_xlate = (state_q == dcm_pkg::ST_XLATE);
  assign st_act = (state_q == dcm_pkg::ST_ACT);
  assign st_wb = (state_q == dcm_pkg::ST_WB);
  assign req_take = req_valid_i && req_ready_o;
  // Hit writeback-invalidate only checks the ring when it degrades to hit invalidate
  assign priv_op = (req_i.op != dcm_pkg::OP_HIT_WRITEBACK_INVALIDATE) ||
                   !dcm_pkg::HAS_WRITEBACK;
  assign illegal_w = (req_i.op == dcm_pkg::OP_INDEX_UNLOCK) && !dcm_pkg::HAS_LOCKING;
  assign priv_w = priv_op && (req_i.ring != '0);
  assign early_exc = illegal_w || priv_w;

  // ==========================================================
  // Line selection
  logic [SB-1:0] set_w;
  logic [dcm_pkg::WAY_BITS-1:0] way_field;
  logic [TB-1:0] tag_w;
  logic way_ok, is_hit_op, is_wb_op;
  logic [W-1:0] hit_v, valid_v, dirty_v, lock_v, sel_v;
  logic [W-1:0] f_valid, f_lock, fill_we, victim;
  logic [TB-1:0] tag_v [W];
  logic [W-1:0] inv_c, clean_c, unl_c, inv_q, clean_q, unl_q, inv_m, clean_m, unl_m;
  logic commit, need_wb, ecc_trap;
  logic [SB-1:0] fill_set;
  logic [TB-1:0] sel_tag;

  assign set_w = line_q[dcm_pkg::ADDR_Y-1:dcm_pkg::ADDR_Z];
  assign way_field = line_q[dcm_pkg::ADDR_X-1:dcm_pkg::ADDR_Y];
  assign tag_w = line_q[31:dcm_pkg::ADDR_Y];
  assign way_ok = (32'(way_field) < W);
  assign is_hit_op = (op_q == dcm_pkg::OP_HIT_WRITEBACK_INVALIDATE);
  assign is_wb_op = is_hit_op || (op_q == dcm_pkg::OP_INDEX_WRITEBACK);
  assign fill_set = fill_i.addr[dcm_pkg::ADDR_Y-1:dcm_pkg::ADDR_Z];

  // ==========================================================
  // Per-way tag, state and lock arrays
  for (genvar w = 0; w < W; w++) begin : g_way
    logic [dcm_pkg::SETS-1:0] valid_q, dirty_q, lock_q;
    logic [TB-1:0] tag_q [dcm_pkg::SETS];

    assign valid_v[w] = valid_q[set_w];
    assign dirty_v[w] = dirty_q[set_w];
    assign lock_v[w] = lock_q[set_w];
    assign tag_v[w] = tag_q[set_w];
    assign hit_v[w] = valid_q[set_w] && (tag_q[set_w] == tag_w);
    // Index operations never translate; the way is a plain address field
    assign sel_v[w] = is_hit_op ? hit_v[w] :
                      (way_field == dcm_pkg::WAY_BITS'(w));
    assign f_valid[w] = valid_q[fill_set];
    assign f_lock[w] = lock_q[fill_set];

    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        valid_q <= '0;
        dirty_q <= '0;
        lock_q <= '0;
      end else if (fill_we[w]) begin
        valid_q[fill_set] <= 1'b1;
        dirty_q[fill_set] <= fill_i.dirty && dcm_pkg::HAS_WRITEBACK;
        lock_q[fill_set] <= fill_i.lock && dcm_pkg::HAS_LOCKING;
      end else if (commit) begin
        if (inv_m[w]) valid_q[set_w] <= 1'b0;
        if (inv_m[w] || clean_m[w]) dirty_q[set_w] <= 1'b0;
        if (unl_m[w]) lock_q[set_w] <= 1'b0;
      end
    end

    always_ff @(posedge clk_i) begin
      if (fill_we[w]) tag_q[fill_set] <= fill_i.addr[31:dcm_pkg::ADDR_Y];
    end
  end

  // ==========================================================
  // Action decode
  // Locked lines survive invalidation; dirty ones are still cleaned by hit writeback-invalidate, not by index invalidate
  assign inv_c = (is_hit_op ? sel_v :
                  (op_q != dcm_pkg::OP_INDEX_INVALIDATE) ? '0 :
                  (dcm_pkg::INVAL_ALL_WAYS && way_ok) ? {W{1'b1}} : sel_v) & ~lock_v;
  assign clean_c = (is_wb_op && dcm_pkg::HAS_WRITEBACK) ? (sel_v & valid_v & dirty_v) :
                   '0;
  assign unl_c = (op_q == dcm_pkg::OP_INDEX_UNLOCK) ? sel_v : '0;
  assign need_wb = |clean_c;
  assign ecc_trap = dcm_pkg::HAS_ECC && tag_err_i &&
                    ((op_q == dcm_pkg::OP_INDEX_UNLOCK) ||
                     (op_q == dcm_pkg::OP_INDEX_WRITEBACK));
  assign inv_m = st_wb ? inv_q : inv_c;
  assign clean_m = st_wb ? clean_q : clean_c;
  assign unl_m = st_wb ? unl_q : unl_c;
  // Trapped operations reach no commit
  assign commit = (st_act && !ecc_trap && !need_wb) || (st_wb && wb_ready_i);

  always_comb begin
    sel_tag = '0;
    for (int w = 0; w < W; w++) begin
      if (clean_c[w]) sel_tag = tag_v[w];
    end
  end

  // ==========================================================
  // Victim choice for fills
  logic [dcm_pkg::WAY_BITS-1:0] rr_q;
  logic fill_take;

  always_comb begin
    victim = '0;
    for (int w = W - 1; w >= 0; w--) begin
      if (!f_lock[w]) victim = W'(1) << w;
    end
    if (!f_lock[rr_q]) victim = W'(1) << rr_q;
    for (int w = W - 1; w >= 0; w--) begin
      if (!f_lock[w] && !f_valid[w]) victim = W'(1) << w;
    end
  end

  assign fill_take = fill_valid_i && st_idle && !req_take;
  // All ways locked: the fill is acknowledged but dropped
  assign fill_we = fill_take ? (victim & ~f_lock) : '0;

  // ==========================================================
  // Sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      dcm_pkg::ST_IDLE: begin
        if (req_take && !early_exc) begin
          state_d = (req_i.op == dcm_pkg::OP_HIT_WRITEBACK_INVALIDATE) ?
                    dcm_pkg::ST_XLATE : dcm_pkg::ST_ACT;
        end
      end
      dcm_pkg::ST_XLATE: begin
        if (xlate_valid_i) state_d = xlate_i.ok ? dcm_pkg::ST_ACT : dcm_pkg::ST_IDLE;
      end
      dcm_pkg::ST_ACT: begin
        state_d = (need_wb && !ecc_trap) ? dcm_pkg::ST_WB : dcm_pkg::ST_IDLE;
      end
      dcm_pkg::ST_WB: begin
        if (wb_ready_i) state_d = dcm_pkg::ST_IDLE;
      end
      default: state_d = dcm_pkg::ST_IDLE;
    endcase
  end

  logic xfault, exc_d, done_d;
  dcm_pkg::cause_t cause_d, xcause;

  assign xfault = st_xlate && xlate_valid_i && !xlate_i.ok;
  assign xcause = (dcm_pkg::HAS_PROTECTION && xlate_i.prohibited) ?
                  dcm_pkg::CAUSE_LOAD_FORBIDDEN : xlate_i.cause;
  assign exc_d = (st_idle && req_take && early_exc) || xfault || (st_act && ecc_trap);
  assign done_d = (st_idle && req_take && early_exc) || xfault || commit ||
                  (st_act && ecc_trap);
  assign cause_d = xfault ? xcause :
                   (st_act && ecc_trap) ? dcm_pkg::CAUSE_MEMORY_ERROR_TRAP :
                   illegal_w ? dcm_pkg::CAUSE_ILLEGAL_INSTRUCTION :
                   dcm_pkg::CAUSE_PRIVILEGE_VIOLATION;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= dcm_pkg::ST_IDLE;
      op_q <= dcm_pkg::OP_INDEX_INVALIDATE;
      vaddr_q <= '0;
      line_q <= '0;
      req_ready_o <= 1'b0;
      done_o <= 1'b0;
      exc_valid_o <= 1'b0;
      exc_cause_o <= dcm_pkg::CAUSE_NONE;
      exception_virtual_address_reg_o <= '0;
      xlate_req_o <= 1'b0;
      wb_valid_o <= 1'b0;
      wb_addr_o <= '0;
      fill_ack_o <= 1'b0;
      rr_q <= '0;
      inv_q <= '0;
      clean_q <= '0;
      unl_q <= '0;
    end else begin
      state_q <= state_d;
      req_ready_o <= (state_d == dcm_pkg::ST_IDLE);
      done_o <= done_d;
      exc_valid_o <= exc_d;
      xlate_req_o <= (state_d == dcm_pkg::ST_XLATE);
      wb_valid_o <= (state_d == dcm_pkg::ST_WB);
      fill_ack_o <= fill_take;
      if (exc_d) exc_cause_o <= cause_d;
      if (req_take) begin
        op_q <= req_i.op;
        vaddr_q <= vaddr_w;
        line_q <= vaddr_w;
      end
      if (st_xlate && xlate_valid_i && xlate_i.ok) line_q <= xlate_i.paddr;
      if (xfault) exception_virtual_address_reg_o <= vaddr_q;
      if (st_act) begin
        inv_q <= inv_c;
        clean_q <= clean_c;
        unl_q <= unl_c;
        wb_addr_o <= {is_hit_op ? tag_w : sel_tag, set_w, {dcm_pkg::ADDR_Z{1'b0}}};
      end
      if (|fill_we) rr_q <= (rr_q == dcm_pkg::WAY_BITS'(W - 1)) ? '0 : rr_q + 1'b1;
    end
  end

  assign xlate_vaddr_o = vaddr_q;

  // ==========================================================
  // Checks
  a_addr_scale: assert property (@(posedge clk_i) disable iff (!rst_n)
    req_take && !early_exc && req_i.op == dcm_pkg::OP_HIT_WRITEBACK_INVALIDATE |=>
      xlate_vaddr_o == $past(req_i.base) + {$past(req_i.offset), 2'b00})
    else $error("word scaled address wrong");
  a_xlate_fault: assert property (@(posedge clk_i) disable iff (!rst_n)
    xfault |=> exc_valid_o && done_o && exception_virtual_address_reg_o == $past(vaddr_q))
    else $error("translation fault not reported");
  a_prohibit_cause: assert property (@(posedge clk_i) disable iff (!rst_n)
    xfault && xlate_i.prohibited |=> exc_cause_o == dcm_pkg::CAUSE_LOAD_FORBIDDEN)
    else $error("prohibited translation cause wrong");
  a_index_no_xlate: assert property (@(posedge clk_i) disable iff (!rst_n)
    st_xlate |-> is_hit_op)
    else $error("index operation translated");
  a_locked_kept: assert property (@(posedge clk_i) disable iff (!rst_n)
    commit |-> (inv_m & lock_v) == '0)
    else $error("locked line invalidated");
  a_priv_trap: assert property (@(posedge clk_i) disable iff (!rst_n)
    req_take && req_i.op != dcm_pkg::OP_HIT_WRITEBACK_INVALIDATE && req_i.ring != '0 |=>
      exc_valid_o && exc_cause_o inside {dcm_pkg::CAUSE_PRIVILEGE_VIOLATION,
      dcm_pkg::CAUSE_ILLEGAL_INSTRUCTION} && st_idle)
    else $error("privileged operation not trapped");
  a_absent_way: assert property (@(posedge clk_i) disable iff (!rst_n)
    st_act && !is_hit_op && !way_ok |-> (inv_c | clean_c | unl_c) == '0)
    else $error("absent way acted upon");
  a_ecc_quiet: assert property (@(posedge clk_i) disable iff (!rst_n)
    st_act && ecc_trap |-> !commit ##1 exc_valid_o && exc_cause_o ==
      dcm_pkg::CAUSE_MEMORY_ERROR_TRAP && !wb_valid_o)
    else $error("memory error mishandled");
  a_wb_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
    wb_valid_o && !wb_ready_i |=> wb_valid_o && $stable(wb_addr_o))
    else $error("writeback request dropped");
  a_one_line: assert property (@(posedge clk_i) disable iff (!rst_n)
    commit |-> $onehot0(clean_m))
    else $error("more than one line written back");
  a_victim_free: assert property (@(posedge clk_i) disable iff (!rst_n)
    fill_take && !(&f_lock) |-> $onehot(fill_we) && ((fill_we & f_lock) == '0))
    else $error("locked line replaced");

endmodule : dcache_maintenance_ops

`default_nettype wire

// ---- include/dcm_pkg.sv ----
`default_nettype none

package dcm_pkg;

  // ==========================================================
  // Cache geometry
  localparam int unsigned CACHE_BYTES = 3072;
  localparam int unsigned WAYS = 3;
  localparam int unsigned LINE_BYTES = 16;
  localparam int unsigned ADDR_X = $clog2(CACHE_BYTES);
  localparam int unsigned ADDR_Y = $clog2(CACHE_BYTES / WAYS);
  localparam int unsigned ADDR_Z = $clog2(LINE_BYTES);
  localparam int unsigned WAY_BITS = ADDR_X - ADDR_Y;
  localparam int unsigned SET_BITS = ADDR_Y - ADDR_Z;
  localparam int unsigned SETS = 1 << SET_BITS;
  localparam int unsigned TAG_BITS = 32 - ADDR_Y;

  // ==========================================================
  // Build options
  localparam logic HAS_WRITEBACK = 1'b1;
  localparam logic HAS_LOCKING = 1'b1;
  localparam logic HAS_PROTECTION = 1'b1;
  localparam logic HAS_ECC = 1'b1;
  localparam logic INVAL_ALL_WAYS = 1'b0;

  // ==========================================================
  // Offset scaling and field widths
  localparam int unsigned WORD_SHIFT = 2;
  localparam int unsigned LINE_SHIFT = 4;
  localparam int unsigned RING_BITS = 2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    OP_HIT_WRITEBACK_INVALIDATE = 2'h0,
    OP_INDEX_INVALIDATE = 2'h1,
    OP_INDEX_UNLOCK = 2'h2,
    OP_INDEX_WRITEBACK = 2'h3
  } op_t;

  typedef enum logic [2:0] {
    CAUSE_NONE = 3'h0,
    CAUSE_ILLEGAL_INSTRUCTION = 3'h1,
    CAUSE_PRIVILEGE_VIOLATION = 3'h2,
    CAUSE_LOAD_FORBIDDEN = 3'h3,
    CAUSE_MEMORY_ERROR_TRAP = 3'h4,
    CAUSE_XLATE_OTHER = 3'h5
  } cause_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_XLATE = 4'h2,
    ST_ACT = 4'h4,
    ST_WB = 4'h8
  } state_t;

  typedef struct packed {
    op_t op;
    logic [31:0] base;
    logic [7:0] offset;
    logic [RING_BITS-1:0] ring;
  } req_t;

  typedef struct packed {
    logic ok;
    logic prohibited;
    cause_t cause;
    logic [31:0] paddr;
  } xlate_rsp_t;

  typedef struct packed {
    logic [31:0] addr;
    logic lock;
    logic dirty;
  } fill_t;

endpackage : dcm_pkg

`default_nettype wire

// ---- design/dcm_addr_former.sv ----
`timescale 1ns/1ps
`default_nettype none

module dcm_addr_former (
  // Request fields
  input wire dcm_pkg::op_t op_i,
  input wire logic [31:0] base_i,
  input wire logic [7:0] offset_i,
  // Formed address
  output logic [31:0] vaddr_o
);

  // ==========================================================
  // Offset scaling
  logic word_scaled;
  logic [31:0] word_off;
  logic [31:0] line_off;

  assign word_scaled = (op_i == dcm_pkg::OP_HIT_WRITEBACK_INVALIDATE) ||
                       (op_i == dcm_pkg::OP_INDEX_INVALIDATE);
  // Eight-bit field, four-byte units, up to 1020
  assign word_off = {24'h000000, offset_i} << dcm_pkg::WORD_SHIFT;
  // Low four bits only, sixteen-byte units, up to 240
  assign line_off = {28'h0000000, offset_i[3:0]} << dcm_pkg::LINE_SHIFT;
  assign vaddr_o = base_i + (word_scaled ? word_off : line_off);

endmodule : dcm_addr_former

`default_nettype wire

// ---- verif/dcm_far_side.sv ----
`timescale 1ns/1ps
`default_nettype none

module dcm_far_side (
  // Clock
  input wire logic clk_i,
  // Translation side
  input wire logic xlate_req_i,
  input wire logic [31:0] xlate_vaddr_i,
  input wire logic fault_i,
  input wire logic [3:0] delay_i,
  output logic xlate_valid_o,
  output dcm_pkg::xlate_rsp_t xlate_o,
  // Line writeback side
  input wire logic wb_valid_i,
  input wire logic [31:0] wb_addr_i,
  output logic wb_ready_o,
  output int wb_count_o,
  output logic [31:0] wb_last_o
);
  int xw;
  int ww;

  initial begin
    xlate_valid_o = 1'b0;
    xlate_o = '0;
    wb_ready_o = 1'b0;
    wb_count_o = 0;
    wb_last_o = '0;
    xw = 0;
    ww = 0;
  end

  // ==========================================================
  // Translator: answers after delay_i idle cycles
  always @(posedge clk_i) begin
    xlate_valid_o <= 1'b0;
    // Outside an answer the bus is inverted every cycle, so it carries the last result on alternate cycles
    xlate_o <= ~xlate_o;
    if (xlate_req_i && !xlate_valid_o) begin
      if (xw >= delay_i) begin
        xw <= 0;
        xlate_valid_o <= 1'b1;
        xlate_o.ok <= !fault_i;
        xlate_o.prohibited <= fault_i;
        xlate_o.cause <= fault_i ? dcm_pkg::CAUSE_LOAD_FORBIDDEN : dcm_pkg::CAUSE_NONE;
        xlate_o.paddr <= xlate_vaddr_i;
      end else begin
        xw <= xw + 1;
      end
    end
  end

  // ==========================================================
  // Memory: stalls each writeback by delay_i cycles
  always @(posedge clk_i) begin
    wb_ready_o <= 1'b0;
    if (wb_valid_i && wb_ready_o) begin
      wb_count_o <= wb_count_o + 1;
      wb_last_o <= wb_addr_i;
    end else if (wb_valid_i) begin
      if (ww >= delay_i) begin
        ww <= 0;
        wb_ready_o <= 1'b1;
      end else begin
        ww <= ww + 1;
      end
    end
  end
endmodule : dcm_far_side

`default_nettype wire

// ---- verif/dcache_maintenance_ops_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module dcache_maintenance_ops_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic req_valid = 1'b0;
  dcm_pkg::req_t req = '0;
  logic req_ready, done, exc_valid, xlate_req, xlate_valid, wb_valid, wb_ready, fill_ack;
  dcm_pkg::cause_t exc_cause;
  logic [31:0] evaddr, xlate_vaddr, wb_addr, wb_last;
  dcm_pkg::xlate_rsp_t xlate;
  logic tag_err = 1'b0;
  logic fill_valid = 1'b0;
  dcm_pkg::fill_t fill = '0;
  logic fault = 1'b0;
  logic [3:0] delay = 4'h1;
  int wb_count, bad_count = 0, num_checks = 0, lat;
  logic seen_done, seen_exc;
  logic [2:0] seen_cause;

  always #10 clk = ~clk;

  dcache_maintenance_ops dcache_maintenance_ops_inst (.clk_i(clk), .reset_n_i(reset_n),
    .req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready), .done_o(done),
    .exc_valid_o(exc_valid), .exc_cause_o(exc_cause),
    .exception_virtual_address_reg_o(evaddr), .xlate_req_o(xlate_req),
    .xlate_vaddr_o(xlate_vaddr), .xlate_valid_i(xlate_valid), .xlate_i(xlate),
    .tag_err_i(tag_err), .wb_valid_o(wb_valid), .wb_addr_o(wb_addr), .wb_ready_i(wb_ready),
    .fill_valid_i(fill_valid), .fill_i(fill), .fill_ack_o(fill_ack));

  dcm_far_side dcm_far_side_inst (.clk_i(clk), .xlate_req_i(xlate_req),
    .xlate_vaddr_i(xlate_vaddr), .fault_i(fault), .delay_i(delay), .xlate_valid_o(xlate_valid),
    .xlate_o(xlate), .wb_valid_i(wb_valid), .wb_addr_i(wb_addr), .wb_ready_o(wb_ready),
    .wb_count_o(wb_count), .wb_last_o(wb_last));

  // ==========================================================
  // Shared tasks, all entered and left at a falling edge
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic run_op(input dcm_pkg::op_t op, input logic [31:0] base,
                        input logic [7:0] off, input logic [1:0] ring);
    int n;
    n = 0;
    req_valid = 1'b1;
    req = '{op: op, base: base, offset: off, ring: ring};
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    req_valid = 1'b0;
    // Released fields carry junk so a late sample shows up
    req = ~req;
    lat = 0;
    while (done !== 1'b1 && lat < 200) begin
      @(negedge clk);
      lat++;
    end
    seen_done = done;
    seen_exc = exc_valid;
    seen_cause = exc_cause;
    @(negedge clk);
  endtask : run_op

  task automatic do_fill(input logic [31:0] addr, input logic lock, input logic dirty);
    fill_valid = 1'b1;
    fill = '{addr: addr, lock: lock, dirty: dirty};
    @(negedge clk);
    fill_valid = 1'b0;
    fill = ~fill;
    check(fill_ack, 1'b1);
    @(negedge clk);
  endtask : do_fill

  // Index writeback, expecting one line out or none
  task automatic idx_wb(input logic [31:0] base, input logic [7:0] off,
                        input int expect_n, input logic [31:0] addr);
    int c0;
    c0 = wb_count;
    run_op(dcm_pkg::OP_INDEX_WRITEBACK, base, off, 2'h0);
    check(seen_done, 1'b1);
    check(32'(wb_count - c0), 32'(expect_n));
    if (expect_n == 1) check(wb_last, addr);
  endtask : idx_wb

  // ==========================================================
  // Scenarios
  task automatic t_privilege;
    do_fill(32'h0000_7010, 1'b0, 1'b1);
    for (int i = 1; i < 4; i++) begin
      run_op(dcm_pkg::op_t'(i), 32'h0000_0010, 8'h00, 2'(i));
      check(seen_exc, 1'b1);
      check(seen_cause, dcm_pkg::CAUSE_PRIVILEGE_VIOLATION);
      check(lat, 0);
    end
    idx_wb(32'h0000_0010, 8'h00, 1, 32'h0000_7010);
  endtask : t_privilege

  task automatic t_writeback;
    do_fill(32'h1234_5050, 1'b0, 1'b1);
    // Upper nibble of the offset must be ignored
    idx_wb(32'h0000_0010, 8'hf4, 1, 32'h1234_5050);
    idx_wb(32'h0000_0050, 8'h00, 0, '0);
    check(lat, 1);
  endtask : t_writeback

  task automatic t_invalidate;
    do_fill(32'h0000_a070, 1'b0, 1'b1);
    do_fill(32'h5000_03f0, 1'b0, 1'b1);
    run_op(dcm_pkg::OP_INDEX_INVALIDATE, 32'h0000_0010, 8'h18, 2'h0);
    check(seen_exc, 1'b0);
    run_op(dcm_pkg::OP_INDEX_INVALIDATE, 32'h0000_0000, 8'hff, 2'h0);
    idx_wb(32'h0000_0070, 8'h00, 0, '0);
    idx_wb(32'h0000_03f0, 8'h00, 0, '0);
  endtask : t_invalidate

  task automatic t_locked;
    do_fill(32'h0000_b090, 1'b1, 1'b1);
    run_op(dcm_pkg::OP_INDEX_INVALIDATE, 32'h0000_0090, 8'h00, 2'h0);
    check(seen_exc, 1'b0);
    idx_wb(32'h0000_0090, 8'h00, 1, 32'h0000_b090);
    do_fill(32'h0000_c0a0, 1'b1, 1'b1);
    run_op(dcm_pkg::OP_INDEX_UNLOCK, 32'h0000_0000, 8'h0a, 2'h0);
    check(seen_exc, 1'b0);
    run_op(dcm_pkg::OP_INDEX_INVALIDATE, 32'h0000_00a0, 8'h00, 2'h0);
    idx_wb(32'h0000_00a0, 8'h00, 0, '0);
  endtask : t_locked

  task automatic t_ways;
    do_fill(32'h0000_10d0, 1'b0, 1'b1);
    run_op(dcm_pkg::OP_INDEX_INVALIDATE, 32'h0000_0c00, 8'h34, 2'h0);
    check(seen_exc, 1'b0);
    idx_wb(32'h0000_0cd0, 8'h00, 0, '0);
    idx_wb(32'h0000_00d0, 8'h00, 1, 32'h0000_10d0);
    do_fill(32'h0000_20e0, 1'b0, 1'b1);
    do_fill(32'h0000_30e0, 1'b0, 1'b1);
    run_op(dcm_pkg::OP_INDEX_INVALIDATE, 32'h0000_04e0, 8'h00, 2'h0);
    idx_wb(32'h0000_04e0, 8'h00, 0, '0);
    idx_wb(32'h0000_00e0, 8'h00, 1, 32'h0000_20e0);
  endtask : t_ways

  task automatic t_hit;
    int c0;
    do_fill(32'h2000_0100, 1'b0, 1'b1);
    fault = 1'b1;
    run_op(dcm_pkg::OP_HIT_WRITEBACK_INVALIDATE, 32'h2000_0100, 8'h03, 2'h1);
    check(xlate_vaddr, 32'h2000_010c);
    check(seen_cause, dcm_pkg::CAUSE_LOAD_FORBIDDEN);
    check(evaddr, 32'h2000_010c);
    fault = 1'b0;
    idx_wb(32'h0000_0100, 8'h00, 1, 32'h2000_0100);
    do_fill(32'h3000_0110, 1'b0, 1'b1);
    delay = 4'h3;
    c0 = wb_count;
    run_op(dcm_pkg::OP_HIT_WRITEBACK_INVALIDATE, 32'h3000_0100, 8'h04, 2'h0);
    check(seen_exc, 1'b0);
    check(32'(wb_count - c0), 32'h1);
    check(wb_last, 32'h3000_0110);
    delay = 4'h1;
  endtask : t_hit

  task automatic t_mem_err;
    do_fill(32'h0000_4120, 1'b0, 1'b1);
    tag_err = 1'b1;
    idx_wb(32'h0000_0120, 8'h00, 0, '0);
    check(seen_cause, dcm_pkg::CAUSE_MEMORY_ERROR_TRAP);
    run_op(dcm_pkg::OP_INDEX_UNLOCK, 32'h0000_0120, 8'h00, 2'h0);
    check(seen_exc, 1'b1);
    check(seen_cause, dcm_pkg::CAUSE_MEMORY_ERROR_TRAP);
    tag_err = 1'b0;
    idx_wb(32'h0000_0120, 8'h00, 1, 32'h0000_4120);
  endtask : t_mem_err

  // ==========================================================
  // Verdict and main sequence
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    // Two-stage reset release: ready only from the third edge on
    repeat (3) @(negedge clk);
    t_privilege();
    t_writeback();
    t_invalidate();
    t_locked();
    t_ways();
    t_hit();
    t_mem_err();
    complete_run();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #200us;
    bad_count++;
    complete_run();
  end
endmodule : dcache_maintenance_ops_test

`default_nettype wire
